// ### rtl/pfa_defines.svh
`ifndef PFA_DEFINES_SVH
`define PFA_DEFINES_SVH

// Command and response type codes.
`define PFA_CMD_ASSIGN 8'h28
`define PFA_CMD_QUERY 8'h29
`define PFA_RSP_ASSIGN 8'hA8
`define PFA_RSP_QUERY 8'hA9

// Response and reason codes.
`define PFA_RC_SUCCESS 16'h0000
`define PFA_RC_FAILED 16'h0001
`define PFA_REASON_NONE 16'h0000
`define PFA_REASON_LENGTH 16'h0001
`define PFA_REASON_RANGE 16'h0002
`define PFA_REASON_UNKNOWN 16'h0003

// Capability limits fixed for this build.
`define PFA_MAX_CHANNELS 4
`define PFA_MAX_ENDPOINTS 4
`define PFA_MAX_WORDS 9
`define PFA_FUNC_BITS 32

// Reset values of the applied configuration.
`define PFA_RESET_CHAN_MAP 32'h0000_0001
`define PFA_RESET_ENABLE 32'h0000_0001
`define PFA_RESET_EP_MAP 32'h0000_0001

// Payload word index of the first bitmap, bytes 16 to 19.
`define PFA_FIRST_WORD 4

`endif

// ### rtl/pfa_pkg.sv
package pfa_pkg;
    typedef logic [31:0] pfa_word_t;
    typedef logic [7:0] pfa_cmd_t;
    typedef logic [2:0] pfa_count_t;
    typedef logic [3:0] pfa_index_t;
    typedef logic [5:0] pfa_fcount_t;
    typedef logic [4:0] pfa_part_t;
endpackage

// ### rtl/pfa_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pfa_link_if;
    import pfa_pkg::*;
    // Command stream, one payload word per beat after the header.
    logic cmd_start;
    pfa_cmd_t cmd_type;
    logic cmd_valid;
    pfa_word_t cmd_word;
    logic cmd_last;
    // Response, one pulse when the answer is ready.
    logic rsp_valid;
    pfa_cmd_t rsp_type;
    logic [15:0] rsp_code;
    logic [15:0] rsp_reason;
    pfa_word_t rsp_config;

    modport device (input cmd_start, cmd_type, cmd_valid, cmd_word, cmd_last,
        output rsp_valid, rsp_type, rsp_code, rsp_reason, rsp_config);
    modport manager (output cmd_start, cmd_type, cmd_valid, cmd_word, cmd_last,
        input rsp_valid, rsp_type, rsp_code, rsp_reason, rsp_config);
endinterface
`default_nettype wire

// ### rtl/pfa_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defines.svh"

// What this block does
// - Command 0x28 assigns and enables functions.
// - One channel bitmap per reported channel.
// - Function bits start at bit 0.
// - Endpoint bitmaps follow enablement when endpoints exceed one.
// - Single-endpoint devices carry no endpoint bitmaps.
// - Accepted values pend until next PCIe reset.
// - Applied configuration persists until replaced.
// - Payload word order: channels, enablement, endpoints.
// - Channel bit set means function assigned.
// - Assigned disabled functions still get partition identifiers.
// - Enablement bit n enables function n.
// - Endpoint bit n assigns function n.
// - Successful assignment answers with type 0xA8.
// - Assignment answer carries response and reason codes.
// - Command 0x29 queries channel configuration.
// - Query command carries no payload words.
// - Partition ids ascend by function number from 0.
// - Successful query answers with type 0xA9.
module pfa_device
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Link to the management controller.
    pfa_link_if.device link,
    // Capabilities and platform events.
    input wire pfa_pkg::pfa_count_t channel_count,
    input wire pfa_pkg::pfa_count_t endpoint_count,
    input wire pfa_pkg::pfa_fcount_t reported_function_count,
    input wire logic pcie_reset,
    input wire logic [1:0] query_channel,
    // Applied configuration.
    output pfa_pkg::pfa_word_t applied_enable,
    output pfa_pkg::pfa_word_t applied_chan_map [`PFA_MAX_CHANNELS],
    output pfa_pkg::pfa_word_t applied_ep_map [`PFA_MAX_ENDPOINTS],
    output pfa_pkg::pfa_part_t partition_id [`PFA_MAX_CHANNELS][`PFA_FUNC_BITS],
    output logic config_pending
);
    import pfa_pkg::*;

    typedef enum logic [2:0]
    {
        PFA_IDLE = 3'b001,
        PFA_COLLECT = 3'b010,
        PFA_ANSWER = 3'b100
    } pfa_state_t;

    pfa_state_t state_q;
    pfa_state_t state_d;
    pfa_cmd_t type_q;
    pfa_index_t count_q;
    logic overrun_q;
    logic range_bad_q;
    pfa_word_t words_q [`PFA_MAX_WORDS];
    pfa_word_t pend_enable_q;
    pfa_word_t pend_chan_q [`PFA_MAX_CHANNELS];
    pfa_word_t pend_ep_q [`PFA_MAX_ENDPOINTS];
    logic pcie_meta_q;
    logic pcie_sync_q;
    logic pcie_prev_q;

    // Words expected: channels plus enablement plus endpoints when more than one.
    wire logic multi_ep = endpoint_count > 3'h1;
    wire pfa_index_t expect_words = multi_ep
        ? pfa_index_t'({1'b0, channel_count}) + pfa_index_t'({1'b0, endpoint_count}) + 4'h1
        : pfa_index_t'({1'b0, channel_count}) + 4'h1;
    wire pfa_word_t func_mask = (reported_function_count >= 6'h20) ? 32'hFFFFFFFF
        : ((32'h00000001 << reported_function_count) - 32'h00000001);
    wire logic is_assign = type_q == `PFA_CMD_ASSIGN;
    wire logic is_query = type_q == `PFA_CMD_QUERY;
    wire logic len_ok = is_query ? (count_q == 4'h0) : (!overrun_q && count_q == expect_words);
    wire logic assign_ok = is_assign && len_ok && !range_bad_q;
    wire logic beat = state_q == PFA_COLLECT && link.cmd_valid;
    wire logic word_bad = (link.cmd_word & ~func_mask) != 32'h0;
    wire logic pcie_rise = pcie_sync_q && !pcie_prev_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            PFA_IDLE:
                if (link.cmd_start)
                    state_d = link.cmd_valid ? PFA_COLLECT : PFA_ANSWER;
            PFA_COLLECT:
                if (link.cmd_valid && link.cmd_last)
                    state_d = PFA_ANSWER;
            PFA_ANSWER:
                state_d = PFA_IDLE;
            default:
                state_d = PFA_IDLE;
        endcase
    end

    // Reset strobe comes from another domain, so it is synchronised first.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pcie_meta_q <= 1'b0;
            pcie_sync_q <= 1'b0;
            pcie_prev_q <= 1'b0;
        end
        else
        begin
            pcie_meta_q <= pcie_reset;
            pcie_sync_q <= pcie_meta_q;
            pcie_prev_q <= pcie_sync_q;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q <= PFA_IDLE;
            type_q <= 8'h00;
            count_q <= 4'h0;
            overrun_q <= 1'b0;
            range_bad_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            // A start sets the count outright, so a finished command's count cannot leak in.
            if (state_q == PFA_IDLE && link.cmd_start)
            begin
                type_q <= link.cmd_type;
                count_q <= link.cmd_valid ? 4'h1 : 4'h0;
                overrun_q <= 1'b0;
                range_bad_q <= link.cmd_valid && word_bad;
            end
            else if (beat)
            begin
                if (count_q == 4'(`PFA_MAX_WORDS))
                    overrun_q <= 1'b1;
                else
                    count_q <= count_q + 4'h1;
                if (word_bad)
                    range_bad_q <= 1'b1;
            end
        end
    end

    // Payload words are parked by index; the first beat may come with the start strobe.
    wire pfa_index_t wr_index = (state_q == PFA_IDLE) ? 4'h0 : count_q;
    wire logic wr_en = (state_q == PFA_IDLE && link.cmd_start && link.cmd_valid) || beat;
    always_ff @(posedge clk_sys)
    begin
        if (wr_en && wr_index < 4'(`PFA_MAX_WORDS))
            words_q[wr_index] <= link.cmd_word;
    end

    // Pending store is written only by a clean assignment; the applied set only on PCIe reset.
    wire logic latch_pend = state_q == PFA_ANSWER && assign_ok;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pend_enable_q <= `PFA_RESET_ENABLE;
            applied_enable <= `PFA_RESET_ENABLE;
            config_pending <= 1'b0;
        end
        else
        begin
            if (latch_pend)
            begin
                pend_enable_q <= words_q[channel_count];
                config_pending <= 1'b1;
            end
            else if (pcie_rise)
                config_pending <= 1'b0;
            if (pcie_rise)
                applied_enable <= pend_enable_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PFA_MAX_CHANNELS; g = g + 1)
        begin : gen_chan
            wire logic present = 3'(g) < channel_count;
            always_ff @(posedge clk_sys or posedge reset)
            begin
                if (reset)
                begin
                    pend_chan_q[g] <= `PFA_RESET_CHAN_MAP;
                    applied_chan_map[g] <= `PFA_RESET_CHAN_MAP;
                end
                else
                begin
                    if (latch_pend)
                        pend_chan_q[g] <= present ? words_q[g] : 32'h0;
                    if (pcie_rise)
                        applied_chan_map[g] <= pend_chan_q[g];
                end
            end
            // Partition index counts assigned lower functions, enabled or not.
            genvar f;
            for (f = 0; f < `PFA_FUNC_BITS; f = f + 1)
            begin : gen_func
                if (f == 0)
                    assign partition_id[g][f] = 5'h00;
                else
                    assign partition_id[g][f] = 5'($countones(applied_chan_map[g][f-1:0]));
            end
        end
        for (g = 0; g < `PFA_MAX_ENDPOINTS; g = g + 1)
        begin : gen_ep
            wire logic present = multi_ep && (3'(g) < endpoint_count);
            wire pfa_index_t src = 4'(g) + pfa_index_t'({1'b0, channel_count}) + 4'h1;
            always_ff @(posedge clk_sys or posedge reset)
            begin
                if (reset)
                begin
                    pend_ep_q[g] <= `PFA_RESET_EP_MAP;
                    applied_ep_map[g] <= `PFA_RESET_EP_MAP;
                end
                else
                begin
                    if (latch_pend)
                        pend_ep_q[g] <= present ? words_q[src] : 32'h0;
                    if (pcie_rise)
                        applied_ep_map[g] <= pend_ep_q[g];
                end
            end
        end
    endgenerate

    // Answer: configuration word holds 0x01 in its top byte and the enabled count of the queried channel.
    wire pfa_word_t q_map = applied_chan_map[query_channel];
    wire pfa_word_t query_word = {8'h01, 8'h00, 10'h000,
        6'($countones(q_map & applied_enable))};
    wire logic answer_ok = is_query ? len_ok : assign_ok;
    wire logic [15:0] reason = (!is_assign && !is_query) ? `PFA_REASON_UNKNOWN
        : !len_ok ? `PFA_REASON_LENGTH
        : (is_assign && range_bad_q) ? `PFA_REASON_RANGE : `PFA_REASON_NONE;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            link.rsp_valid <= 1'b0;
            link.rsp_type <= 8'h00;
            link.rsp_code <= 16'h0000;
            link.rsp_reason <= 16'h0000;
            link.rsp_config <= 32'h0;
        end
        else
        begin
            link.rsp_valid <= state_q == PFA_ANSWER;
            if (state_q == PFA_ANSWER)
            begin
                link.rsp_type <= is_query ? `PFA_RSP_QUERY : `PFA_RSP_ASSIGN;
                link.rsp_code <= answer_ok ? `PFA_RC_SUCCESS : `PFA_RC_FAILED;
                link.rsp_reason <= reason;
                link.rsp_config <= is_query ? query_word : 32'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/pfa_manager.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defines.svh"

// Management controller end: sends one command from a word list, then waits for the answer.
module pfa_manager
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Link to the device.
    pfa_link_if.manager link,
    // User request.
    input wire logic send,
    input wire logic send_query,
    input wire pfa_pkg::pfa_count_t channel_count,
    input wire pfa_pkg::pfa_count_t endpoint_count,
    input wire pfa_pkg::pfa_word_t chan_map [`PFA_MAX_CHANNELS],
    input wire pfa_pkg::pfa_word_t enable_map,
    input wire pfa_pkg::pfa_word_t ep_map [`PFA_MAX_ENDPOINTS],
    output logic busy,
    output logic done,
    output logic ok,
    output pfa_pkg::pfa_word_t result_config
);
    import pfa_pkg::*;

    typedef enum logic [2:0]
    {
        PFM_IDLE = 3'b001,
        PFM_SEND = 3'b010,
        PFM_WAIT = 3'b100
    } pfm_state_t;

    pfm_state_t state_q;
    pfa_index_t idx_q;
    pfa_index_t total_q;
    logic query_q;

    // Word order: channel maps, enablement, then endpoint maps when more than one endpoint.
    wire logic multi_ep = endpoint_count > 3'h1;
    wire pfa_index_t n_words = multi_ep
        ? pfa_index_t'({1'b0, channel_count}) + pfa_index_t'({1'b0, endpoint_count}) + 4'h1
        : pfa_index_t'({1'b0, channel_count}) + 4'h1;
    wire pfa_index_t ch_n = pfa_index_t'({1'b0, channel_count});
    // The first word rides with the start strobe, so idle always points at word 0.
    wire logic in_idle = state_q == PFM_IDLE;
    wire pfa_index_t cur_idx = in_idle ? 4'h0 : idx_q;
    wire pfa_index_t cur_total = in_idle ? n_words : total_q;
    wire pfa_index_t ep_i = cur_idx - ch_n - 4'h1;
    wire pfa_word_t word_sel = (cur_idx < ch_n) ? chan_map[cur_idx[1:0]]
        : (cur_idx == ch_n) ? enable_map : ep_map[ep_i[1:0]];
    wire logic start = in_idle && send;
    wire logic word_valid = (start && !send_query) || state_q == PFM_SEND;
    wire logic word_last = word_valid && cur_idx == cur_total - 4'h1;

    assign link.cmd_start = start;
    assign link.cmd_type = send_query ? `PFA_CMD_QUERY : `PFA_CMD_ASSIGN;
    assign link.cmd_valid = word_valid;
    assign link.cmd_word = word_sel;
    assign link.cmd_last = word_last;
    assign busy = state_q != PFM_IDLE;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q <= PFM_IDLE;
            idx_q <= 4'h0;
            total_q <= 4'h0;
            query_q <= 1'b0;
            done <= 1'b0;
            ok <= 1'b0;
            result_config <= 32'h0;
        end
        else
        begin
            done <= 1'b0;
            case (state_q)
                PFM_IDLE:
                    if (send)
                    begin
                        query_q <= send_query;
                        idx_q <= 4'h1;
                        total_q <= n_words;
                        state_q <= (send_query || word_last) ? PFM_WAIT : PFM_SEND;
                    end
                PFM_SEND:
                    if (word_last)
                        state_q <= PFM_WAIT;
                    else
                        idx_q <= idx_q + 4'h1;
                PFM_WAIT:
                    if (link.rsp_valid)
                    begin
                        done <= 1'b1;
                        ok <= link.rsp_code == `PFA_RC_SUCCESS && link.rsp_type ==
                            (query_q ? `PFA_RSP_QUERY : `PFA_RSP_ASSIGN);
                        result_config <= link.rsp_config;
                        state_q <= PFM_IDLE;
                    end
                default:
                    state_q <= PFM_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### tb/pfa_link_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defines.svh"

module pfa_link_checker
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Command stream.
    input wire logic cmd_start,
    input wire pfa_pkg::pfa_cmd_t cmd_type,
    input wire logic cmd_valid,
    input wire pfa_pkg::pfa_word_t cmd_word,
    input wire logic cmd_last,
    // Response.
    input wire logic rsp_valid,
    input wire pfa_pkg::pfa_cmd_t rsp_type,
    input wire logic [15:0] rsp_code,
    input wire logic [15:0] rsp_reason,
    input wire pfa_pkg::pfa_word_t rsp_config
);
    import pfa_pkg::*;

    // Tracks one outstanding command, so answers can be tied to a request.
    logic open_q;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            open_q <= 1'h0;
        else if (cmd_start)
            open_q <= 1'h1;
        else if (rsp_valid)
            open_q <= 1'h0;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    rsp_pulse_a: assert property (
        rsp_valid |=> !rsp_valid)
        else $error("response valid longer than one cycle");
    assign_answer_a: assert property (
        cmd_valid && cmd_last |-> ##1 !rsp_valid ##1 rsp_valid && rsp_type == `PFA_RSP_ASSIGN)
        else $error("assignment answer late or of wrong type");
    query_answer_a: assert property (
        cmd_start && cmd_type == `PFA_CMD_QUERY |-> !cmd_valid ##1 !cmd_valid && !rsp_valid
            ##1 rsp_valid && rsp_type == `PFA_RSP_QUERY)
        else $error("query carried words or got a wrong answer");
    ok_reason_a: assert property (
        rsp_valid && rsp_code == `PFA_RC_SUCCESS |-> rsp_reason == `PFA_REASON_NONE)
        else $error("success answer with a reason");
    fail_reason_a: assert property (
        rsp_valid && rsp_code != `PFA_RC_SUCCESS |-> rsp_code == `PFA_RC_FAILED
            && rsp_reason inside {`PFA_REASON_LENGTH, `PFA_REASON_RANGE, `PFA_REASON_UNKNOWN})
        else $error("failure answer with a bad code");
    rsp_hold_a: assert property (
        !rsp_valid |-> $stable(rsp_code) && $stable(rsp_reason))
        else $error("response codes changed without an answer");
    one_open_a: assert property (
        cmd_start |-> !open_q)
        else $error("command started while one is outstanding");
    word_start_a: assert property (
        cmd_start && cmd_type == `PFA_CMD_ASSIGN |-> cmd_valid)
        else $error("assignment start without its first word");
    last_word_a: assert property (
        cmd_last |-> cmd_valid && open_q)
        else $error("last marker outside a word");
    answer_only_a: assert property (
        rsp_valid |-> open_q)
        else $error("answer without a command");
endmodule
`default_nettype wire

// ### tb/pfa_assign_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defines.svh"

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module pf_assignment_command_handler_tb_top;
    import pfa_pkg::*;

    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic pcie_reset = 1'h0;
    logic send = 1'h0;
    logic send_query = 1'h0;
    logic [1:0] query_channel = 2'h0;
    pfa_count_t ch_cnt = 3'h1;
    pfa_count_t ep_cnt = 3'h1;
    pfa_count_t man_ep = 3'h1;
    pfa_fcount_t func_cnt = 6'h06;
    pfa_word_t chan_map [`PFA_MAX_CHANNELS] = '{default: 32'h0};
    pfa_word_t ep_map [`PFA_MAX_ENDPOINTS] = '{default: 32'h0};
    pfa_word_t enable_map = 32'h0;
    pfa_word_t applied_enable;
    pfa_word_t applied_chan_map [`PFA_MAX_CHANNELS];
    pfa_word_t applied_ep_map [`PFA_MAX_ENDPOINTS];
    pfa_part_t partition_id [`PFA_MAX_CHANNELS][`PFA_FUNC_BITS];
    logic config_pending;
    logic busy;
    logic done;
    logic ok;
    pfa_word_t result_config;
    int error_cnt = 0;
    int total_checks = 0;

    always #20 clk_sys = ~clk_sys;

    pfa_link_if pfa_link_if_inst();

    pfa_device pfa_device_inst (.clk_sys(clk_sys), .reset(reset), .link(pfa_link_if_inst),
        .channel_count(ch_cnt), .endpoint_count(ep_cnt), .reported_function_count(func_cnt),
        .pcie_reset(pcie_reset), .query_channel(query_channel),
        .applied_enable(applied_enable), .applied_chan_map(applied_chan_map),
        .applied_ep_map(applied_ep_map), .partition_id(partition_id),
        .config_pending(config_pending));

    // The manager gets its own endpoint count so a length mismatch can be provoked.
    pfa_manager pfa_manager_inst (.clk_sys(clk_sys), .reset(reset), .link(pfa_link_if_inst),
        .send(send), .send_query(send_query), .channel_count(ch_cnt),
        .endpoint_count(man_ep), .chan_map(chan_map), .enable_map(enable_map),
        .ep_map(ep_map), .busy(busy), .done(done), .ok(ok), .result_config(result_config));

    pfa_link_checker pfa_link_checker_inst (.clk_sys(clk_sys), .reset(reset),
        .cmd_start(pfa_link_if_inst.cmd_start), .cmd_type(pfa_link_if_inst.cmd_type),
        .cmd_valid(pfa_link_if_inst.cmd_valid), .cmd_word(pfa_link_if_inst.cmd_word),
        .cmd_last(pfa_link_if_inst.cmd_last), .rsp_valid(pfa_link_if_inst.rsp_valid),
        .rsp_type(pfa_link_if_inst.rsp_type), .rsp_code(pfa_link_if_inst.rsp_code),
        .rsp_reason(pfa_link_if_inst.rsp_reason), .rsp_config(pfa_link_if_inst.rsp_config));

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic run(input logic q);
        int i;
        @(negedge clk_sys);
        send = 1'h1;
        send_query = q;
        @(negedge clk_sys);
        send = 1'h0;
        for (i = 0; i < 60 && done !== 1'h1; i++)
            @(negedge clk_sys);
        if (done !== 1'h1)
        begin
            error_cnt++;
            end_sim();
        end
    endtask

    // Three edges are spent in the synchroniser and edge detect, so six cycles is ample.
    task automatic pcie();
        @(negedge clk_sys);
        pcie_reset = 1'h1;
        repeat (6) @(negedge clk_sys);
        pcie_reset = 1'h0;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic t_multi();
        ch_cnt = 3'h2;
        ep_cnt = 3'h2;
        man_ep = 3'h2;
        chan_map[0] = 32'h0000_0005;
        chan_map[1] = 32'h0000_0002;
        enable_map = 32'h0000_0001;
        ep_map[0] = 32'h0000_0005;
        ep_map[1] = 32'h0000_0002;
        run(1'h0);
        `CHK(ok, 1'h1)
        `CHK(pfa_link_if_inst.rsp_code, 16'h0000)
        `CHK(config_pending, 1'h1)
        `CHK(applied_chan_map[0], 32'h0000_0001)
        pcie();
        `CHK(config_pending, 1'h0)
        `CHK(applied_chan_map[0], 32'h0000_0005)
        `CHK(applied_chan_map[1], 32'h0000_0002)
        `CHK(applied_enable, 32'h0000_0001)
        `CHK(applied_ep_map[1], 32'h0000_0002)
        `CHK(applied_ep_map[0], 32'h0000_0005)
        `CHK(partition_id[0][2], 5'h01)
        pcie();
        `CHK(applied_chan_map[0], 32'h0000_0005)
    endtask

    task automatic t_range();
        chan_map[0] = 32'h0000_0040;
        run(1'h0);
        `CHK(ok, 1'h0)
        `CHK(pfa_link_if_inst.rsp_reason, 16'h0002)
        `CHK(config_pending, 1'h0)
        pcie();
        `CHK(applied_chan_map[0], 32'h0000_0005)
    endtask

    task automatic t_single();
        ch_cnt = 3'h1;
        ep_cnt = 3'h1;
        man_ep = 3'h1;
        chan_map[0] = 32'h0000_0021;
        enable_map = 32'h0000_0021;
        run(1'h0);
        `CHK(ok, 1'h1)
        man_ep = 3'h2;
        run(1'h0);
        `CHK(pfa_link_if_inst.rsp_reason, 16'h0001)
        pcie();
        `CHK(applied_chan_map[0], 32'h0000_0021)
        `CHK(applied_enable, 32'h0000_0021)
        `CHK(partition_id[0][5], 5'h01)
    endtask

    task automatic t_query();
        run(1'h1);
        `CHK(ok, 1'h1)
        `CHK(pfa_link_if_inst.rsp_type, 8'hA9)
        `CHK(result_config, 32'h0100_0002)
        `CHK(busy, 1'h0)
    endtask

    initial
    begin
        repeat (20) @(negedge clk_sys);
        reset = 1'h0;
        `CHK(applied_enable, 32'h0000_0001)
        `CHK(config_pending, 1'h0)
        t_multi();
        t_range();
        t_single();
        t_query();
        end_sim();
    end
endmodule
`default_nettype wire
